// ==== hdl/smbus_csr_read_access.sv ====
// Contract
// - Data bytes go out MSB byte first.
// - Answer at address 68h unless overridden.
// - Byte count four; first command byte 04h.
// - Byte two bits 3-0 are port [4:1].
// - Byte three bit 7 is port [0].
// - Byte three bits 5-2 are byte enables.
// - Byte three bits 1-0 are address [11:10].
// - Byte four is address bits [9:2].
// - Read address answered with count then data.
// - Command CDh is a process-call read.
// - Process call: repeated start, no stop.
// - Optional PEC byte follows data byte four.
// - Address bits 1-0 always zero.
// - Port selector picks port 0 to 5.
`include "smbus_rd_cfg.svh"
module smbus_csr_read_access #(
  parameter logic [6:0] DEV_ADDR = `SMB_DEF_ADDR
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic scl_link_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_ovr_en_i,
  input wire logic [6:0] addr_ovr_i,
  input wire logic pec_en_i,
  output logic csr_req_o,
  output logic [4:0] csr_port_o,
  output logic [11:0] csr_addr_o,
  output logic [3:0] csr_be_o,
  input wire logic csr_ack_i,
  input wire logic [31:0] csr_rdata_i,
  output logic busy_o
);
  import smbus_rd_pkg::*;

  state_t s;
  state_t n;
  logic lk_bit;
  logic lk_tog;

  smbus_link_sampler u_link (
    .scl_link_i(scl_link_i),
    .rst_b_i(rst_b_i),
    .sda_i(sda_i),
    .bit_o(lk_bit),
    .tog_o(lk_tog)
  );

  // Byte sent at each position of the read answer.
  function automatic logic [7:0] tx_byte(input logic [2:0] txi, input logic [31:0] d, input logic [7:0] crc);
    logic [7:0] b;
    b = crc;
    unique case (txi)
      `SMB_TXI_CNT: b = `SMB_BYTE_CNT;
      `SMB_TXI_D1: b = d[31:24];
      `SMB_TXI_D2: b = d[23:16];
      `SMB_TXI_D3: b = d[15:8];
      `SMB_TXI_D4: b = d[7:0];
      default: b = crc;
    endcase
    return b;
  endfunction

  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [7:0] b;
  logic [7:0] tb;
  logic [6:0] my_addr;
  logic [4:0] psel;
  logic [2:0] last_txi;

  always_comb begin
    n = s;
    n.scl_s = {s.scl_s[1:0], scl_link_i};
    n.sda_s = {s.sda_s[1:0], sda_i};
    n.tog_s = {s.tog_s[1:0], lk_tog};
    rise = s.tog_s[2] ^ s.tog_s[1];
    fall = s.scl_s[2] & ~s.scl_s[1];
    start = s.scl_s[2] & s.scl_s[1] & s.sda_s[2] & ~s.sda_s[1];
    stop = s.scl_s[2] & s.scl_s[1] & ~s.sda_s[2] & s.sda_s[1];
    b = {s.sh[6:0], lk_bit};
    tb = tx_byte(s.txi, s.data, s.crc);
    my_addr = addr_ovr_en_i ? addr_ovr_i : DEV_ADDR;
    psel = {s.cb1[`SMB_PSEL_HI_F], s.cb2[`SMB_PSEL_LO_B]};
    last_txi = pec_en_i ? `SMB_TXI_PEC : `SMB_TXI_D4;

    if (s.req && csr_ack_i) begin
      n.req = 1'b0;
      n.data = csr_rdata_i;
      n.data_ok = 1'b1;
    end

    if (start) begin
      // A repeated start keeps the running CRC so the code covers the whole transaction.
      if (!s.in_txn) begin
        n.crc = `SMB_CRC_INIT;
      end
      n.in_txn = 1'b1;
      n.phase = P_RX;
      n.st = S_ADDR;
      n.cnt = '0;
      n.oe = 1'b0;
      n.txgo = 1'b0;
    end else if (stop) begin
      n.in_txn = 1'b0;
      n.rd_ok = 1'b0;
      n.wait_pec = 1'b0;
      n.phase = P_IDLE;
      n.st = S_ADDR;
      n.oe = 1'b0;
    end else begin
      unique case (s.phase)
        P_IDLE: begin
        end
        P_RX: begin
          if (rise) begin
            n.sh = b;
            n.cnt = s.cnt + 3'd1;
            if (s.cnt == `SMB_LAST_BIT) begin
              n.phase = P_RACK_W;
              n.ack = 1'b0;
              n.crc = crc8(s.crc, b);
              unique case (s.st)
                S_ADDR: begin
                  if (b[7:1] == my_addr) begin
                    if (!b[0]) begin
                      n.ack = 1'b1;
                      n.st = S_CMD;
                    end else if (s.rd_ok && s.data_ok) begin
                      n.ack = 1'b1;
                      n.txgo = 1'b1;
                      n.txi = `SMB_TXI_CNT;
                    end
                  end
                end
                S_CMD: begin
                  if (s.rd_ok) begin
                    // After a complete setup only the host's PEC byte may follow.
                    n.ack = pec_en_i && s.wait_pec && (b == s.crc);
                    n.wait_pec = 1'b0;
                  end else if (b == `SMB_CMD_SETUP || b == `SMB_CMD_PCALL) begin
                    n.ack = 1'b1;
                    n.st = S_CNT;
                  end else if (b == `SMB_CMD_BLK_RD) begin
                    n.ack = 1'b1;
                    n.rd_ok = 1'b1;
                  end
                end
                S_CNT: begin
                  if (b == `SMB_BYTE_CNT) begin
                    n.ack = 1'b1;
                    n.st = S_CB;
                    n.idx = '0;
                  end
                end
                S_CB: begin
                  n.ack = 1'b1;
                  n.idx = s.idx + 2'd1;
                  unique case (s.idx)
                    2'd0: n.ack = (b == `SMB_OP_READ);
                    2'd1: n.cb1 = b;
                    2'd2: n.cb2 = b;
                    default: begin
                      n.addr = {s.cb2[`SMB_ADDR_HI_F], b, 2'b00};
                      n.be = s.cb2[`SMB_BE_F];
                      n.port = psel;
                      if (psel <= `SMB_PORT_MAX) begin
                        n.req = 1'b1;
                        n.data_ok = 1'b0;
                      end else begin
                        // Reserved selectors reach no port and read back as zero.
                        n.data = '0;
                        n.data_ok = 1'b1;
                        n.req = 1'b0;
                      end
                      n.rd_ok = 1'b1;
                      n.wait_pec = 1'b1;
                      n.st = S_CMD;
                    end
                  endcase
                end
                default: begin
                end
              endcase
              if (!n.ack) begin
                n.txgo = 1'b0;
              end
            end
          end
        end
        P_RACK_W: begin
          if (fall) begin
            n.oe = s.ack;
            n.phase = P_RACK;
          end
        end
        P_RACK: begin
          if (fall) begin
            n.oe = 1'b0;
            n.cnt = '0;
            if (!s.ack) begin
              n.phase = P_IDLE;
            end else if (s.txgo) begin
              n.txgo = 1'b0;
              n.sh = {tb[6:0], 1'b0};
              n.oe = ~tb[7];
              n.crc = crc8(s.crc, tb);
              n.phase = P_TX;
            end else begin
              n.phase = P_RX;
            end
          end
        end
        P_LOAD: begin
          if (fall) begin
            n.sh = {tb[6:0], 1'b0};
            n.oe = ~tb[7];
            n.cnt = '0;
            if (s.txi != `SMB_TXI_PEC) begin
              n.crc = crc8(s.crc, tb);
            end
            n.phase = P_TX;
          end
        end
        P_TX: begin
          if (rise) begin
            n.cnt = s.cnt + 3'd1;
            if (s.cnt == `SMB_LAST_BIT) begin
              n.phase = P_TACK_W;
            end
          end else if (fall) begin
            n.oe = ~s.sh[7];
            n.sh = {s.sh[6:0], 1'b0};
          end
        end
        P_TACK_W: begin
          if (fall) begin
            n.oe = 1'b0;
            n.phase = P_TACK;
          end
        end
        P_TACK: begin
          if (rise) begin
            if (!lk_bit && s.txi != last_txi) begin
              n.txi = s.txi + 3'd1;
              n.phase = P_LOAD;
            end else begin
              n.phase = P_IDLE;
            end
          end
        end
        default: begin
          n.phase = P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '{scl_s: 3'b111, sda_s: 3'b111, tog_s: 3'b000, phase: P_IDLE, st: S_ADDR,
             crc: `SMB_CRC_INIT, default: '0};
    end else begin
      s <= n;
    end
  end

  assign sda_o = s.sda_out;
  assign sda_oe_o = s.oe;
  assign csr_req_o = s.req;
  assign csr_port_o = s.port;
  assign csr_addr_o = s.addr;
  assign csr_be_o = s.be;
  assign busy_o = s.in_txn;

endmodule

// ==== common/smbus_rd_cfg.svh ====
`ifndef SMBUS_RD_CFG_SVH
`define SMBUS_RD_CFG_SVH

// Target address and command codes.
`define SMB_DEF_ADDR 7'h68
`define SMB_CMD_SETUP 8'hBA
`define SMB_CMD_BLK_RD 8'hBD
`define SMB_CMD_PCALL 8'hCD
`define SMB_BYTE_CNT 8'h04
`define SMB_OP_READ 8'h04

// Command byte fields.
`define SMB_PSEL_HI_F 3:0
`define SMB_PSEL_LO_B 7
`define SMB_BE_F 5:2
`define SMB_ADDR_HI_F 1:0
`define SMB_PORT_MAX 5'h05

// Byte counters.
`define SMB_LAST_BIT 3'h7
`define SMB_LAST_CB 2'h3
`define SMB_TXI_CNT 3'h0
`define SMB_TXI_D1 3'h1
`define SMB_TXI_D2 3'h2
`define SMB_TXI_D3 3'h3
`define SMB_TXI_D4 3'h4
`define SMB_TXI_PEC 3'h5

// Packet error code.
`define SMB_CRC_POLY 8'h07
`define SMB_CRC_INIT 8'h00

`endif

// ==== common/smbus_rd_pkg.sv ====
`include "smbus_rd_cfg.svh"

package smbus_rd_pkg;

  typedef enum logic [2:0] {
    P_IDLE,
    P_RX,
    P_RACK_W,
    P_RACK,
    P_LOAD,
    P_TX,
    P_TACK_W,
    P_TACK
  } phase_t;

  typedef enum logic [1:0] {
    S_ADDR,
    S_CMD,
    S_CNT,
    S_CB
  } txn_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] tog_s;
    phase_t phase;
    txn_t st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic ack;
    logic txgo;
    logic [1:0] idx;
    logic [2:0] txi;
    logic [7:0] cb1;
    logic [7:0] cb2;
    logic [7:0] crc;
    logic in_txn;
    logic rd_ok;
    logic wait_pec;
    logic [31:0] data;
    logic data_ok;
    logic req;
    logic [4:0] port;
    logic [11:0] addr;
    logic [3:0] be;
    logic oe;
    logic sda_out;
  } state_t;

  // SMBus CRC-8, polynomial x^8 + x^2 + x + 1, one byte at a time.
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `SMB_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

// ==== hdl/smbus_link_sampler.sv ====
// Runs on the SMBus clock itself: each rising edge catches the data line and flips a toggle.
// The caught bit stays still for a whole bus clock period, so the core may read it once the
// synchronised toggle shows a new edge.
module smbus_link_sampler (
  input wire logic scl_link_i,
  input wire logic rst_b_i,
  input wire logic sda_i,
  output logic bit_o,
  output logic tog_o
);

  always_ff @(posedge scl_link_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_o <= 1'b1;
      tog_o <= 1'b0;
    end else begin
      bit_o <= sda_i;
      tog_o <= ~tog_o;
    end
  end

endmodule

// ==== verif/smbus_csr_read_access_properties.sv ====
module smbus_csr_read_access_properties (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic scl_link_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic csr_req_o,
  input wire logic [4:0] csr_port_o,
  input wire logic [11:0] csr_addr_o,
  input wire logic [3:0] csr_be_o,
  input wire logic csr_ack_i,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_wait;
    csr_req_o && !csr_ack_i;
  endsequence
  sequence s_taken;
    csr_req_o && csr_ack_i;
  endsequence
  chk_addr_align: assert property (csr_addr_o[1:0] == 2'h0) else $error("address not aligned");
  chk_port_range: assert property (csr_req_o |-> csr_port_o <= 5'h05) else $error("port out of range");
  chk_req_hold: assert property (s_wait |=> csr_req_o && $stable(csr_port_o)
    && $stable(csr_addr_o) && $stable(csr_be_o)) else $error("request not held");
  chk_req_drop: assert property (s_taken |=> !csr_req_o) else $error("request not dropped");
  chk_sda_low: assert property (sda_o == 1'b0) else $error("data line driven high");
  chk_oe_scl: assert property ($changed(sda_oe_o) |-> !scl_link_i) else $error("data moved with clock high");
  chk_oe_idle: assert property (!busy_o |-> !sda_oe_o) else $error("driving outside transaction");
  chk_req_busy: assert property ($rose(csr_req_o) |-> busy_o) else $error("request outside transaction");
endmodule

// ==== verif/smbus_host_model.sv ====
module smbus_host_model (
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // The clock rests high between frames; a released data line reads the pull-up.
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic start();
    #20 sda_pull_o = 1'b0;
    #20 scl_o = 1'b1;
    #40 sda_pull_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask
  task automatic stop();
    #20 sda_pull_o = 1'b1;
    #20 scl_o = 1'b1;
    #40 sda_pull_o = 1'b0;
    #40;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #20 sda_pull_o = !b;
    #20 scl_o = 1'b1;
    #20 r = sda_i;
    #20 scl_o = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Every returned byte is acknowledged, the packet error code too.
  task automatic rd_byte(output logic [7:0] b);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      b = {b[6:0], r};
    end
    bit_io(1'b0, r);
  endtask
endmodule

// ==== verif/smbus_csr_read_access_bench.sv ====
module smbus_csr_read_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b;
  logic scl, pull, sda_o, sda_oe, csr_req, busy;
  logic ovr_en = 1'b0;
  logic pec_en = 1'b0;
  logic csr_ack = 1'b0;
  logic [6:0] ovr = 7'h00;
  logic [4:0] port;
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] rdata = 32'h0000_0000;
  logic [7:0] crc;
  wire logic sda = !(pull || sda_oe);
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int reqs = 0;
  always #2 clk = ~clk;
  smbus_csr_read_access dut_u (.clk_sys_i(clk), .rst_b_i(rst_b), .scl_link_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_ovr_en_i(ovr_en), .addr_ovr_i(ovr), .pec_en_i(pec_en),
    .csr_req_o(csr_req), .csr_port_o(port), .csr_addr_o(addr), .csr_be_o(be), .csr_ack_i(csr_ack),
    .csr_rdata_i(rdata), .busy_o(busy));
  smbus_host_model host_u (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));
  // Register side answers one cycle late with data built from the request fields.
  always @(posedge clk) begin
    csr_ack <= csr_req && !csr_ack;
    rdata <= {3'h0, port, be, addr, 8'h5A};
    if (csr_req && csr_ack) reqs++;
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] crc_next(logic [7:0] c, logic [7:0] b);
    c ^= b;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction
  task automatic wb(input logic [7:0] b, input logic exp);
    logic ack;
    host_u.wr_byte(b, ack);
    crc = crc_next(crc, b);
    check("ack", ack, exp);
  endtask
  task automatic rb(output logic [7:0] b);
    host_u.rd_byte(b);
    crc = crc_next(crc, b);
  endtask
  task automatic run_read(input logic [7:0] cmd, c2, c3, c4, output logic [31:0] d);
    logic [7:0] b, e;
    crc = 8'h00;
    host_u.start();
    wb(8'hD0, 1'b1);
    wb(cmd, 1'b1);
    wb(8'h04, 1'b1);
    wb(8'h04, 1'b1);
    wb(c2, 1'b1);
    wb(c3, 1'b1);
    wb(c4, 1'b1);
    if (cmd == 8'hBA) begin
      host_u.stop();
      crc = 8'h00;
      host_u.start();
      wb(8'hD0, 1'b1);
      wb(8'hBD, 1'b1);
    end
    host_u.start();
    wb(8'hD1, 1'b1);
    rb(b);
    check("count", b, 8'h04);
    for (int i = 0; i < 4; i++) begin
      rb(b);
      d = {d[23:0], b};
    end
    if (pec_en) begin
      e = crc;
      rb(b);
      check("pec", b, e);
    end
    host_u.stop();
  endtask
  task automatic t_separate();
    logic [31:0] d;
    run_read(8'hBA, 8'h00, 8'hBC, 8'h3E, d);
    check("port", port, 5'h01);
    check("addr", addr, 12'h0F8);
    check("be", be, 4'hF);
    check("data", d, {3'h0, 5'h01, 4'hF, 12'h0F8, 8'h5A});
    check("busy", busy, 1'b0);
    check("sda_o", sda_o, 1'b0);
  endtask
  task automatic t_pcall();
    logic [31:0] d;
    @(posedge clk) pec_en <= 1'b1;
    run_read(8'hCD, 8'h02, 8'hAA, 8'h81, d);
    check("pcall", d, {3'h0, 5'h05, 4'hA, 12'hA04, 8'h5A});
    @(posedge clk) pec_en <= 1'b0;
  endtask
  task automatic t_refuse();
    logic [31:0] d;
    int n;
    n = reqs;
    run_read(8'hBA, 8'h03, 8'h00, 8'h00, d);
    check("reserved", d, 32'h0000_0000);
    check("reqs", reqs, n);
    host_u.start();
    check("busy", busy, 1'b1);
    wb(8'hA0, 1'b0);
    host_u.stop();
    @(posedge clk) ovr_en <= 1'b1;
    ovr <= 7'h21;
    host_u.start();
    wb(8'h42, 1'b1);
    host_u.stop();
    @(posedge clk) ovr_en <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    // A real falling edge at time zero, so the link sampler is reset before the first bus clock.
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    t_separate();
    t_pcall();
    t_refuse();
    stop_test();
  end
endmodule
bind smbus_csr_read_access smbus_csr_read_access_properties chk_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .scl_link_i(scl_link_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .csr_req_o(csr_req_o), .csr_port_o(csr_port_o),
  .csr_addr_o(csr_addr_o), .csr_be_o(csr_be_o), .csr_ack_i(csr_ack_i), .busy_o(busy_o));
